// *** logic/tcc_core.sv ***
// Timer counter core: counter, control register, flags and APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module tcc_core
  import tcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_count_clock,
  input  wire logic        port_direction_bit,
  output logic             ext_pin_force_input,
  output logic             ext_pin_dir_eff,
  input  wire logic        channel_event,
  input  wire logic        break_active,
  input  wire logic        break_clear_enable,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  output logic [15:0]      counter_value,
  output logic             overflow_event,
  output logic             overflow_irq,
  output logic             channel_irq,
  output logic             wake_req
);

  tcc_core_state_type r;
  tcc_core_state_type n;

  tcc_tick_if tk ();

  logic [TCC_NFLAGS-1:0] set_evt;
  logic [TCC_NFLAGS-1:0] rd_seen;
  logic [TCC_NFLAGS-1:0] wr_zero;
  logic [TCC_NFLAGS-1:0] flags;
  logic                  protect;
  logic                  acc;
  logic                  prep;
  logic                  done;
  logic                  done_ok;
  logic [5:0]            idx;
  logic                  blocked;
  logic                  clr_cmd;
  logic                  run;
  logic                  wrap;
  logic [7:0]            rd_byte;

  function automatic logic tcc_mapped(input logic [5:0] i);
    return (i == TCC_IDX_CTRL) || (i == TCC_IDX_CNTH) ||
           (i == TCC_IDX_CNTL) || (i == TCC_IDX_MODH) ||
           (i == TCC_IDX_MODL) || (i == TCC_IDX_CHAN);
  endfunction : tcc_mapped

  function automatic logic tcc_hit(input logic [5:0] i,
                                   input logic [5:0] want);
    return i == want;
  endfunction : tcc_hit

  tcc_prescaler u_pres (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tk      (tk)
  );

  generate
    for (genvar g = 0; g < TCC_NFLAGS; g++)
    begin : g_flag
      tcc_flag u_flag (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .set_evt (set_evt[g]),
        .rd_seen (rd_seen[g]),
        .wr_zero (wr_zero[g]),
        .protect (protect),
        .hold    (stop_mode),
        .flag    (flags[g])
      );
    end
  endgenerate

  // Bus phases: one wait state, then completion with side effects
  assign idx     = paddr[7:2];
  assign acc     = psel & penable;
  assign prep    = acc & ~r.pready;
  assign done    = acc & r.pready;
  assign done_ok = done & ~r.pslverr;
  // Register file is unreachable while the core sleeps
  assign blocked = wait_mode | stop_mode;

  assign clr_cmd = done_ok & pwrite & tcc_hit(idx, TCC_IDX_CTRL) &
                   pwdata[TCC_BIT_CLR];
  assign run     = ~r.halt & ~break_active & ~stop_mode;
  assign wrap    = tk.tick & ~clr_cmd & (r.cnt == r.modv);

  assign protect = break_active & ~break_clear_enable;

  assign tk.sel     = r.ps;
  assign tk.clr     = clr_cmd;
  assign tk.run     = run;
  assign tk.ext_pin = external_count_clock;

  always_comb
  begin
    set_evt = '0;
    rd_seen = '0;
    wr_zero = '0;
    set_evt[TCC_FLAG_OVF]  = wrap & ~r.mod_inh;
    set_evt[TCC_FLAG_CHAN] = channel_event;
    if (done_ok && !pwrite)
    begin
      rd_seen[TCC_FLAG_OVF]  = tcc_hit(idx, TCC_IDX_CTRL);
      rd_seen[TCC_FLAG_CHAN] = tcc_hit(idx, TCC_IDX_CHAN);
    end
    // Writing one to a flag bit does nothing
    if (done_ok && pwrite)
    begin
      wr_zero[TCC_FLAG_OVF]  = tcc_hit(idx, TCC_IDX_CTRL) &
                               ~pwdata[TCC_BIT_OVF];
      wr_zero[TCC_FLAG_CHAN] = tcc_hit(idx, TCC_IDX_CHAN) &
                               ~pwdata[TCC_BIT_CHF];
    end
  end

  always_comb
  begin
    rd_byte = TCC_BYTE_ZERO;
    case (idx)
      TCC_IDX_CTRL:
        // Clear bit always reads back as zero
        rd_byte = {flags[TCC_FLAG_OVF], r.ovf_ie, r.halt,
                   1'b0, 1'b0, r.ps};
      TCC_IDX_CNTH:
        rd_byte = r.cnt[15:8];
      TCC_IDX_CNTL:
        rd_byte = r.lo_latched ? r.lo_buf : r.cnt[7:0];
      TCC_IDX_MODH:
        rd_byte = r.modv[15:8];
      TCC_IDX_MODL:
        rd_byte = r.modv[7:0];
      TCC_IDX_CHAN:
        rd_byte = {flags[TCC_FLAG_CHAN], r.ch_ie, 6'h00};
      default:
        rd_byte = TCC_BYTE_ZERO;
    endcase
  end

  always_comb
  begin
    n = r;
    n.ovf_pulse = 1'b0;

    if (prep)
    begin
      n.pready  = 1'b1;
      n.prdata  = {TCC_PAD_ZERO, rd_byte};
      n.pslverr = blocked | ~tcc_mapped(idx);
    end
    else if (done)
    begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    // Counting; a clear in the same cycle takes precedence
    if (wrap && run)
    begin
      n.cnt       = TCC_CNT_RESET;
      n.ovf_pulse = ~r.mod_inh;
    end
    else if (tk.tick)
      n.cnt = r.cnt + 16'h0001;

    if (done_ok && pwrite)
    begin
      case (idx)
        TCC_IDX_CTRL:
        begin
          n.ovf_ie = pwdata[TCC_BIT_OVFIE];
          n.halt   = pwdata[TCC_BIT_HALT];
          n.ps     = pwdata[2:0];
          if (pwdata[TCC_BIT_CLR])
          begin
            // Halt in the same write leaves the count parked at zero
            n.cnt        = TCC_CNT_RESET;
            n.lo_latched = 1'b0;
            n.ovf_pulse  = 1'b0;
          end
        end
        TCC_IDX_MODH:
        begin
          n.modv[15:8] = pwdata[7:0];
          n.mod_inh    = 1'b1;
        end
        TCC_IDX_MODL:
        begin
          n.modv[7:0] = pwdata[7:0];
          n.mod_inh   = 1'b0;
        end
        TCC_IDX_CHAN:
          n.ch_ie = pwdata[TCC_BIT_CHIE];
        default:
          n.ch_ie = r.ch_ie;
      endcase
    end
    else if (done_ok && !pwrite)
    begin
      case (idx)
        TCC_IDX_CNTH:
          // Repeated high reads keep the first snapshot
          if (!r.lo_latched)
          begin
            n.lo_buf     = r.cnt[7:0];
            n.lo_latched = 1'b1;
          end
        TCC_IDX_CNTL:
          n.lo_latched = 1'b0;
        default:
          n.lo_latched = r.lo_latched;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r.cnt        <= TCC_CNT_RESET;
      r.modv       <= TCC_MOD_RESET;
      r.mod_inh    <= 1'b0;
      r.ovf_ie     <= 1'b0;
      r.halt       <= TCC_HALT_RST;
      r.ps         <= TCC_PS_RESET;
      r.ch_ie      <= 1'b0;
      r.lo_latched <= 1'b0;
      r.lo_buf     <= TCC_BYTE_ZERO;
      r.ovf_pulse  <= 1'b0;
      r.pready     <= 1'b0;
      r.pslverr    <= 1'b0;
      r.prdata     <= 32'h0000_0000;
    end
    else
      r <= n;
  end

  assign pready  = r.pready;
  assign prdata  = r.prdata;
  assign pslverr = r.pslverr;

  assign counter_value  = r.cnt;
  assign overflow_event = r.ovf_pulse;

  // Pin is taken over as an input whenever it is selected as the count clock, halted or not
  assign ext_pin_force_input = (r.ps == TCC_PS_EXT);
  assign ext_pin_dir_eff     = port_direction_bit &
                               ~ext_pin_force_input;

  assign overflow_irq = flags[TCC_FLAG_OVF] & r.ovf_ie;
  assign channel_irq  = flags[TCC_FLAG_CHAN] & r.ch_ie;
  // Halting before wait stops new overflow wakeups; a set flag or the channel request still wakes
  assign wake_req     = overflow_irq | channel_irq;

endmodule : tcc_core

// *** logic/tcc_flag.sv ***
// Status flag with read-then-write-zero clearing and break protection
`timescale 1ns/1ps
module tcc_flag
  import tcc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic set_evt,
  input  wire logic rd_seen,
  input  wire logic wr_zero,
  input  wire logic protect,
  input  wire logic hold,
  output logic      flag
);

  tcc_flag_state_type r;
  tcc_flag_state_type n;

  always_comb
  begin
    n = r;
    if (hold)
      n = r;
    else if (set_evt)
    begin
      // A fresh event cancels any half-done clear; set wins
      n.flag  = 1'b1;
      n.armed = 1'b0;
    end
    else if (!protect)
    begin
      if (wr_zero && r.armed)
      begin
        n.flag  = 1'b0;
        n.armed = 1'b0;
      end
      else if (rd_seen && r.flag)
        n.armed = 1'b1;
    end
  end

  assign flag = r.flag;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r.flag  <= 1'b0;
      r.armed <= 1'b0;
    end
    else
      r <= n;
  end

endmodule : tcc_flag

// *** logic/tcc_pkg.sv ***
// Shared constants and types for the timer counter core
// Function
// - Overflow flag sets when the counter wraps to zero after matching modulo.
// - Overflow request asserts only while overflow flag and its enable are set.
// - Channel events set the channel flag; request only when channel enabled.
// - Wait mode keeps counting, blocks register access; enabled requests wake.
// - Stop mode freezes everything, keeps all state, resumes where it left.
// - Counter holds still while break is active.
// - With break clear enable high, flags may be cleared during break.
// - With it low, break accesses leave flags; two-step clear survives break.
// - Divider select picks bus clock divided 1 to 64, or external pin.
// - External pin selected forces it to input, else it stays port I/O.
// - Overflow flag clears by read seeing it set, then writing zero.
// - Writing one to overflow flag is ignored; reset clears flag and enable.
// - Halt bit stops counting; reset sets it.
// - Counter clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Halt and clear in one write leave the counter stopped at zero.
// - Reset clears the divider select field, giving the undivided bus clock.
// - High byte read latches low byte; held until the low byte is read or the counter is cleared.
// - Counter bytes are read-only; reset and counter clear zero them.
// - At modulo, flag and restart at zero; high modulo write inhibits flag.
package tcc_pkg;

  localparam logic [5:0] TCC_IDX_CTRL  = 6'h20;
  localparam logic [5:0] TCC_IDX_CNTH  = 6'h21;
  localparam logic [5:0] TCC_IDX_CNTL  = 6'h22;
  localparam logic [5:0] TCC_IDX_MODH  = 6'h23;
  localparam logic [5:0] TCC_IDX_MODL  = 6'h24;
  localparam logic [5:0] TCC_IDX_CHAN  = 6'h25;

  localparam int TCC_BIT_OVF    = 7;
  localparam int TCC_BIT_OVFIE  = 6;
  localparam int TCC_BIT_HALT   = 5;
  localparam int TCC_BIT_CLR    = 4;
  localparam int TCC_BIT_CHF    = 7;
  localparam int TCC_BIT_CHIE   = 6;

  localparam logic [2:0]  TCC_PS_RESET  = 3'h0;
  localparam logic [2:0]  TCC_PS_EXT    = 3'h7;
  localparam logic        TCC_HALT_RST  = 1'b1;
  localparam logic [15:0] TCC_CNT_RESET = 16'h0000;
  localparam logic [15:0] TCC_MOD_RESET = 16'hFFFF;
  localparam logic [7:0]  TCC_BYTE_ZERO = 8'h00;
  localparam logic [23:0] TCC_PAD_ZERO  = 24'h00_0000;
  localparam logic [5:0]  TCC_DIV_RESET = 6'h00;

  localparam int TCC_FLAG_OVF  = 0;
  localparam int TCC_FLAG_CHAN = 1;
  localparam int TCC_NFLAGS    = 2;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] modv;
    logic        mod_inh;
    logic        ovf_ie;
    logic        halt;
    logic [2:0]  ps;
    logic        ch_ie;
    logic        lo_latched;
    logic [7:0]  lo_buf;
    logic        ovf_pulse;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tcc_core_state_type;

  typedef struct packed {
    logic [5:0] div;
    logic [2:0] sync;
  } tcc_pres_state_type;

  typedef struct packed {
    logic flag;
    logic armed;
  } tcc_flag_state_type;

endpackage : tcc_pkg

// *** logic/tcc_prescaler.sv ***
// Bus clock prescaler and external count clock synchroniser
`timescale 1ns/1ps
module tcc_prescaler
  import tcc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  tcc_tick_if.pres  tk
);

  tcc_pres_state_type r;
  tcc_pres_state_type n;

  function automatic logic [5:0] tcc_div_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = (7'h01 << sel) - 7'h01;
    return m[5:0];
  endfunction : tcc_div_mask

  always_comb
  begin
    n = r;
    // Synchroniser runs always so a halted count sees no stale edge
    n.sync = {r.sync[1:0], tk.ext_pin};
    if (tk.clr)
      n.div = TCC_DIV_RESET;
    else if (tk.run)
      n.div = r.div + 6'h01;
  end

  always_comb
  begin
    if (tk.sel == TCC_PS_EXT)
      tk.tick = tk.run & r.sync[1] & ~r.sync[2];
    else
      tk.tick = tk.run &
        ((r.div & tcc_div_mask(tk.sel)) == tcc_div_mask(tk.sel));
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r.div  <= TCC_DIV_RESET;
      r.sync <= 3'h0;
    end
    else
      r <= n;
  end

endmodule : tcc_prescaler

// *** logic/tcc_tick_if.sv ***
// Tick request and answer between the core and its prescaler
`timescale 1ns/1ps
interface tcc_tick_if;
  logic [2:0] sel;
  logic       clr;
  logic       run;
  logic       ext_pin;
  logic       tick;

  modport core (
    output sel,
    output clr,
    output run,
    output ext_pin,
    input  tick
  );

  modport pres (
    input  sel,
    input  clr,
    input  run,
    input  ext_pin,
    output tick
  );
endinterface : tcc_tick_if

// *** tb/tb_top.sv ***
// Self-checking bench for the timer counter core
`timescale 1ns/1ps
module tb_top;
  import tcc_pkg::*;
  logic        clk_sys = 0;
  logic        sys_rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        external_count_clock = 0;
  logic        port_direction_bit = 0;
  logic        channel_event = 0;
  logic        break_active = 0;
  logic        break_clear_enable = 0;
  logic        wait_mode = 0;
  logic        stop_mode = 0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_pin_force_input;
  logic        ext_pin_dir_eff;
  logic [15:0] counter_value;
  logic        overflow_event;
  logic        overflow_irq;
  logic        channel_irq;
  logic        wake_req;
  int          mismatches = 0;
  int          n_tests = 0;
  int          k;
  logic [9:0]  q[$];
  logic [9:0]  e;

  always #12.5 clk_sys = ~clk_sys;

  tcc_core tcc_core_inst (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .external_count_clock,
    .port_direction_bit, .ext_pin_force_input, .ext_pin_dir_eff,
    .channel_event, .break_active, .break_clear_enable, .wait_mode,
    .stop_mode, .counter_value, .overflow_event, .overflow_irq,
    .channel_irq, .wake_req);

  task stop_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [15:0] s, logic [15:0] x);
    n_tests++;
    if (s !== x)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  endtask : chk

  // Reads carry their expected byte in d; the monitor compares it
  task automatic apb(logic w, logic [5:0] a, logic [7:0] d, logic er = 0);
    int n;
    q.push_back({w, er, d});
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // Judge by the answer itself, not the loop count
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    else
    begin
      psel <= 0;
      penable <= 0;
    end
  endtask : apb

  always @(posedge clk_sys)
    if (pready === 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      chk("err", 16'(pslverr), 16'(e[8]));
      if (!e[9])
        chk("rdata", 16'(prdata[7:0]), 16'(e[7:0]));
    end

  // Pin pulses slow enough for the two-stage synchroniser
  task automatic tk(int c);
    repeat (c)
    begin
      @(posedge clk_sys) external_count_clock <= 1;
      repeat (2) @(posedge clk_sys);
      external_count_clock <= 0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : tk

  task automatic wev(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (overflow_event !== 1'b1 && n < 300);
    if (overflow_event !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask : wev

  initial
  begin
    int n;
    void'($urandom(86491));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, TCC_IDX_CTRL, 8'h20);
    apb(0, TCC_IDX_CNTH, 8'h00);
    apb(0, TCC_IDX_CNTL, 8'h00);
    apb(0, 6'h30, 8'h00, 1);
    apb(1, TCC_IDX_MODH, 8'h00);
    apb(1, TCC_IDX_MODL, 8'h01);
    for (int c = 0; c < 7; c++)
    begin
      apb(1, TCC_IDX_CTRL, 8'h10 | 8'(c));
      repeat (3) wev(n);
      chk("period", 16'(n), 16'(2 << c));
    end
    port_direction_bit <= 1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk("dir", 16'(ext_pin_dir_eff), 16'h0001);
    chk("force", 16'(ext_pin_force_input), 16'h0000);
    apb(1, TCC_IDX_CTRL, 8'h37);
    @(posedge clk_sys);
    chk("dir", 16'(ext_pin_dir_eff), 16'h0000);
    chk("force", 16'(ext_pin_force_input), 16'h0001);
    apb(0, TCC_IDX_CTRL, 8'hA7);
    apb(1, TCC_IDX_CTRL, 8'h27);
    tk(2);
    apb(0, TCC_IDX_CNTL, 8'h00);
    apb(1, TCC_IDX_MODL, 8'h10);
    apb(1, TCC_IDX_CTRL, 8'h17);
    k = $urandom_range(12, 1);
    tk(k);
    apb(0, TCC_IDX_CNTH, 8'h00);
    tk(3);
    apb(0, TCC_IDX_CNTH, 8'h00);
    apb(0, TCC_IDX_CNTL, 8'(k));
    apb(0, TCC_IDX_CNTL, 8'(k + 3));
    tk(14 - k);
    chk("irq", 16'(overflow_irq), 16'h0000);
    apb(0, TCC_IDX_CTRL, 8'h87);
    apb(1, TCC_IDX_CTRL, 8'hC7);
    @(posedge clk_sys);
    chk("irq", 16'(overflow_irq), 16'h0001);
    apb(0, TCC_IDX_CTRL, 8'hC7);
    tk(17);
    apb(1, TCC_IDX_CTRL, 8'h47);
    apb(0, TCC_IDX_CTRL, 8'hC7);
    apb(1, TCC_IDX_CTRL, 8'h47);
    apb(0, TCC_IDX_CTRL, 8'h47);
    tk(17);
    apb(0, TCC_IDX_CTRL, 8'hC7);
    break_active <= 1;
    tk(3);
    // High read in break is followed by a low read before leaving
    apb(0, TCC_IDX_CNTH, 8'h00);
    apb(0, TCC_IDX_CNTL, 8'h00);
    apb(1, TCC_IDX_CTRL, 8'h47);
    apb(0, TCC_IDX_CTRL, 8'hC7);
    break_active <= 0;
    apb(1, TCC_IDX_CTRL, 8'h47);
    apb(0, TCC_IDX_CTRL, 8'h47);
    tk(17);
    break_clear_enable <= 1;
    break_active <= 1;
    apb(0, TCC_IDX_CTRL, 8'hC7);
    apb(1, TCC_IDX_CTRL, 8'h47);
    break_active <= 0;
    apb(0, TCC_IDX_CTRL, 8'h47);
    wait_mode <= 1;
    apb(0, TCC_IDX_CTRL, 8'h47, 1);
    tk(17);
    chk("wake", 16'(wake_req), 16'h0001);
    wait_mode <= 0;
    tk(2);
    stop_mode <= 1;
    tk(5);
    stop_mode <= 0;
    apb(0, TCC_IDX_CNTL, 8'h02);
    channel_event <= 1;
    @(posedge clk_sys) channel_event <= 0;
    repeat (2) @(posedge clk_sys);
    chk("chirq", 16'(channel_irq), 16'h0000);
    apb(1, TCC_IDX_CHAN, 8'h40);
    @(posedge clk_sys);
    chk("chirq", 16'(channel_irq), 16'h0001);
    apb(0, TCC_IDX_CHAN, 8'hC0);
    apb(1, TCC_IDX_CHAN, 8'h40);
    @(posedge clk_sys);
    chk("chirq", 16'(channel_irq), 16'h0000);
    // Modulo high write alone must keep the wrap from flagging
    apb(0, TCC_IDX_CTRL, 8'hC7);
    apb(1, TCC_IDX_CTRL, 8'h47);
    apb(1, TCC_IDX_MODH, 8'h00);
    tk(17);
    apb(0, TCC_IDX_CTRL, 8'h47);
    apb(1, TCC_IDX_MODL, 8'h10);
    tk(17);
    apb(0, TCC_IDX_CTRL, 8'hC7);
    stop_test();
  end
endmodule : tb_top

// *** tb/tcc_core_sva.sv ***
// Port-level assertions for the timer counter core
`timescale 1ns/1ps
module tcc_core_sva
  import tcc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        port_direction_bit,
  input wire logic        ext_pin_force_input,
  input wire logic        ext_pin_dir_eff,
  input wire logic        break_active,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic [15:0] counter_value,
  input wire logic        overflow_event,
  input wire logic        overflow_irq,
  input wire logic        channel_irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_lowpwr;
    wait_mode || stop_mode;
  endsequence

  property p_refuse;
    s_req ##0 s_lowpwr |=> pready && pslverr;
  endproperty
  property p_wake;
    wake_req == (overflow_irq || channel_irq);
  endproperty
  property p_pin;
    ext_pin_dir_eff == (port_direction_bit && !ext_pin_force_input);
  endproperty
  // Halted after reset, so the count must sit at zero
  property p_rst;
    $fell(sys_rst) |-> (counter_value == 16'h0000 && !overflow_irq
                        && !ext_pin_force_input)[*3];
  endproperty
  property p_brk;
    break_active && !pready |=> $stable(counter_value);
  endproperty
  property p_stop;
    stop_mode |=> $stable(counter_value) && $stable(overflow_irq);
  endproperty
  property p_ovf;
    overflow_event |-> counter_value <= 16'h0001;
  endproperty
  property p_clrbit;
    pready && !pwrite && paddr[7:2] == TCC_IDX_CTRL |->
      !prdata[TCC_BIT_CLR];
  endproperty

  a_refuse: assert property (p_refuse) else $error("access not refused");
  a_wake: assert property (p_wake) else $error("wake mismatch");
  a_pin: assert property (p_pin) else $error("pin dir wrong");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_brk: assert property (p_brk) else $error("count moved in break");
  a_stop: assert property (p_stop) else $error("moved in stop");
  a_ovf: assert property (p_ovf) else $error("overflow not at wrap");
  a_clrbit: assert property (p_clrbit) else $error("clear bit read 1");
endmodule : tcc_core_sva

bind tcc_core tcc_core_sva tcc_core_sva_inst (.clk_sys, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .port_direction_bit,
  .ext_pin_force_input, .ext_pin_dir_eff, .break_active, .wait_mode,
  .stop_mode, .counter_value, .overflow_event, .overflow_irq, .channel_irq,
  .wake_req);
